// file: hdl/tpm_core.sv
// two-channel pulse modulator and serialiser with shared queue
// Operation
// - two channels, each either modulator or serialiser
// - shared queue of at most eight 32-bit words feeds channels
// - even spread: accumulate value, emit one and subtract period when reached
// - mark/space clear: duty cycle is value over period
// - period register sets cycles per period in every mode
// - mark/space set: high for value cycles, low for rest of period
// - run continuously from data register, or from queue while not empty
// - run bits 0 and 8 start channel; registers writable while stopped
// - serial select bits 1 and 9; serial sends msb first
// - repeat bits 2 and 10 resend last queue word when queue empty
// - idle level bits 3 and 11 fill idle, gaps and tail
// - invert bits 4 and 12 invert the final output
// - source bits 5 and 13 pick queue or data register
// - writing one to bit 6 flushes queue; bit reads zero
// - mark/space bits 7 and 15 ignored in serial mode
// - all control fields zero after reset
// - both channels run on the one modulator clock
// - transfer request goes to dma channel 5
// - period registers reset to 32; shorter truncates, longer pads
// - queue words handed to sharing channels in turn
// - overflow and underflow flags, cleared by writing one
// - dma thresholds for request and urgent signal, default 7
`timescale 1ns/1ns
module tpm_core #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic [1:0] pwm_out,
  output logic dma_req,
  output logic dma_urgent_request_threshold
);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(FIFO_DEPTH);

  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 8 || (1 << PW) != FIFO_DEPTH) begin : g_chk
    $error("fifo depth must be a power of two from 2 to 8");
  end

  // ********************
  // state
  // ********************
  logic [31:0] ctl_q, ctl_d, dma_configuration_q, dma_configuration_d, rdata_q, rdata_d;
  logic [31:0] rng_q [2];
  logic [31:0] rng_d [2];
  logic [31:0] dat_q [2];
  logic [31:0] dat_d [2];
  logic [31:0] mem_q [FIFO_DEPTH];
  logic [31:0] mem_d [FIFO_DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [PW:0] cnt_q, cnt_d;
  logic werr_q, werr_d, rerr_q, rerr_d, turn_q, turn_d;
  logic [1:0] gap_q, gap_d, out_q, out_d;
  tpm_pkg::tpm_state_t st_q [2];
  tpm_pkg::tpm_state_t st_d [2];
  logic [31:0] pos_q [2];
  logic [31:0] pos_d [2];
  logic [31:0] word_q [2];
  logic [31:0] word_d [2];
  logic [31:0] acc_q [2];
  logic [31:0] acc_d [2];
  logic req_q, req_d, pan_q, pan_d;
  logic [1:0] en, ser, rpt, idl, inv, src, ms;

  function automatic logic cbit(input logic [31:0] c, input int ch, input int pos);
    cbit = c[ch * tpm_pkg::CH_STRIDE + pos];
  endfunction

  // ********************
  // next state
  // ********************
  always_comb begin
    logic push, flush, popped, ok, b, status_wr, bnd;
    logic [32:0] sum;
    push = 1'b0;
    flush = 1'b0;
    popped = 1'b0;
    ok = 1'b0;
    b = 1'b0;
    bnd = 1'b0;
    sum = 33'h0;
    status_wr = reg_wr && reg_addr == tpm_pkg::OFS_STATUS;
    ctl_d = ctl_q;
    dma_configuration_d = dma_configuration_q;
    rng_d = rng_q;
    dat_d = dat_q;
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    turn_d = turn_q;
    st_d = st_q;
    pos_d = pos_q;
    word_d = word_q;
    acc_d = acc_q;
    gap_d = gap_q;
    rerr_d = rerr_q & ~(status_wr & reg_wdata[tpm_pkg::S_RERR]);
    werr_d = werr_q & ~(status_wr & reg_wdata[tpm_pkg::S_WERR]);
    for (int i = 0; i < 2; i++) begin
      en[i] = cbit(ctl_q, i, tpm_pkg::B_RUN);
      ser[i] = cbit(ctl_q, i, tpm_pkg::B_SER);
      rpt[i] = cbit(ctl_q, i, tpm_pkg::B_RPT);
      idl[i] = cbit(ctl_q, i, tpm_pkg::B_IDLE);
      inv[i] = cbit(ctl_q, i, tpm_pkg::B_INV);
      src[i] = cbit(ctl_q, i, tpm_pkg::B_SRC);
      ms[i] = cbit(ctl_q, i, tpm_pkg::B_MS);
      if (status_wr && reg_wdata[tpm_pkg::S_GAP + i]) begin
        gap_d[i] = 1'b0;
      end
    end
    // register writes, legal while stopped
    if (reg_wr) begin
      case (reg_addr)
        tpm_pkg::OFS_CTL: begin
          ctl_d = reg_wdata & tpm_pkg::CTL_MASK;
          flush = reg_wdata[tpm_pkg::B_FLUSH];
        end
        tpm_pkg::OFS_DMA_CONFIGURATION: dma_configuration_d = reg_wdata & tpm_pkg::DMA_CONFIGURATION_MASK;
        tpm_pkg::OFS_PERIOD1: rng_d[0] = reg_wdata;
        tpm_pkg::OFS_VALUE1: dat_d[0] = reg_wdata;
        tpm_pkg::OFS_PERIOD2: rng_d[1] = reg_wdata;
        tpm_pkg::OFS_VALUE2: dat_d[1] = reg_wdata;
        tpm_pkg::OFS_FIFO: push = 1'b1;
        default: ;
      endcase
    end
    // channels
    for (int i = 0; i < 2; i++) begin
      b = idl[i];
      if (!en[i]) begin
        st_d[i] = tpm_pkg::TPM_IDLE;
        pos_d[i] = 32'h0;
        acc_d[i] = 32'h0;
      end else begin
        if (st_q[i] == tpm_pkg::TPM_RUN) begin
          pos_d[i] = pos_q[i] + 32'h1;
          if (ser[i]) begin
            if (pos_q[i] < tpm_pkg::WORD_BITS) begin
              b = word_q[i][5'd31 - pos_q[i][4:0]];
            end else begin
              b = idl[i];
            end
          end else if (ms[i]) begin
            b = pos_q[i] < word_q[i];
          end else begin
            sum = {1'b0, acc_q[i]} + {1'b0, word_q[i]};
            if (sum >= {1'b0, rng_q[i]}) begin
              b = 1'b1;
              sum = sum - {1'b0, rng_q[i]};
            end else begin
              b = 1'b0;
            end
            acc_d[i] = sum[31:0];
          end
          bnd = {1'b0, pos_q[i]} + 33'h1 >= {1'b0, rng_q[i]};
        end else begin
          bnd = 1'b1;
        end
        if (bnd) begin
          pos_d[i] = 32'h0;
          ok = 1'b0;
          if (!src[i]) begin
            word_d[i] = dat_q[i];
            ok = 1'b1;
          end else if (!popped && cnt_q != '0 && (src != 2'b11 || turn_q == i[0])) begin
            word_d[i] = mem_q[rp_q];
            rp_d = rp_q + 1'b1;
            popped = 1'b1;
            turn_d = ~turn_q;
            ok = 1'b1;
          end else if (rpt[i] && st_q[i] == tpm_pkg::TPM_RUN) begin
            ok = 1'b1;
          end else if (st_q[i] == tpm_pkg::TPM_RUN) begin
            gap_d[i] = 1'b1;
            rerr_d = 1'b1;
          end
          st_d[i] = ok ? tpm_pkg::TPM_RUN : tpm_pkg::TPM_IDLE;
        end
      end
      out_d[i] = b ^ inv[i];
    end
    // queue pointers and count
    if (push && cnt_q == FULL_CNT) begin
      werr_d = 1'b1;
      push = 1'b0;
    end
    if (push) begin
      mem_d[wp_q] = reg_wdata;
      wp_d = wp_q + 1'b1;
    end
    cnt_d = cnt_q + (PW + 1)'(push) - (PW + 1)'(popped);
    if (flush) begin
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
      turn_d = 1'b0;
    end
    req_d = dma_configuration_q[tpm_pkg::D_EN] && {4'h0, cnt_q} < dma_configuration_q[tpm_pkg::D_TRANSFER_REQUEST_THRESHOLD +: 8];
    pan_d = dma_configuration_q[tpm_pkg::D_EN] && {4'h0, cnt_q} < dma_configuration_q[tpm_pkg::D_URGENT_REQUEST_THRESHOLD +: 8];
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        tpm_pkg::OFS_CTL: rdata_d = ctl_q;
        tpm_pkg::OFS_STATUS: begin
          rdata_d = 32'h0;
          rdata_d[tpm_pkg::S_FULL] = cnt_q == FULL_CNT;
          rdata_d[tpm_pkg::S_EMPTY] = cnt_q == '0;
          rdata_d[tpm_pkg::S_WERR] = werr_q;
          rdata_d[tpm_pkg::S_RERR] = rerr_q;
          rdata_d[tpm_pkg::S_GAP +: 2] = gap_q;
          rdata_d[tpm_pkg::S_STATE] = st_q[0] == tpm_pkg::TPM_RUN;
          rdata_d[tpm_pkg::S_STATE + 1] = st_q[1] == tpm_pkg::TPM_RUN;
        end
        tpm_pkg::OFS_DMA_CONFIGURATION: rdata_d = dma_configuration_q;
        tpm_pkg::OFS_PERIOD1: rdata_d = rng_q[0];
        tpm_pkg::OFS_VALUE1: rdata_d = dat_q[0];
        tpm_pkg::OFS_PERIOD2: rdata_d = rng_q[1];
        tpm_pkg::OFS_VALUE2: rdata_d = dat_q[1];
        default: rdata_d = 32'h0;
      endcase
    end
  end

  // ********************
  // registers
  // ********************
  always_ff @(posedge sys_clk) begin
    mem_q <= mem_d;
    if (rst) begin
      ctl_q <= tpm_pkg::CTL_RST;
      dma_configuration_q <= tpm_pkg::DMA_CONFIGURATION_RST;
      rng_q <= '{tpm_pkg::RNG_RST, tpm_pkg::RNG_RST};
      dat_q <= '{tpm_pkg::DAT_RST, tpm_pkg::DAT_RST};
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      werr_q <= 1'b0;
      rerr_q <= 1'b0;
      turn_q <= 1'b0;
      gap_q <= 2'h0;
      out_q <= 2'h0;
      st_q <= '{tpm_pkg::TPM_IDLE, tpm_pkg::TPM_IDLE};
      pos_q <= '{32'h0, 32'h0};
      word_q <= '{32'h0, 32'h0};
      acc_q <= '{32'h0, 32'h0};
      req_q <= 1'b0;
      pan_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ctl_q <= ctl_d;
      dma_configuration_q <= dma_configuration_d;
      rng_q <= rng_d;
      dat_q <= dat_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      werr_q <= werr_d;
      rerr_q <= rerr_d;
      turn_q <= turn_d;
      gap_q <= gap_d;
      out_q <= out_d;
      st_q <= st_d;
      pos_q <= pos_d;
      word_q <= word_d;
      acc_q <= acc_d;
      req_q <= req_d;
      pan_q <= pan_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign pwm_out = out_q;
  assign dma_req = req_q;
  assign dma_urgent_request_threshold = pan_q;

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_ctl_reset: assert property ($fell(rst) |-> ctl_q == 32'h0)
    else $error("control not zero after reset");
  a_rng_reset: assert property ($fell(rst) |-> rng_q[0] == 32'h20 && rng_q[1] == 32'h20)
    else $error("period not 32 after reset");
  a_fifo_bound: assert property (cnt_q <= FULL_CNT)
    else $error("queue count over depth");
  a_flush_empty: assert property (reg_wr && reg_addr == 6'h00 && reg_wdata[6] |=> cnt_q == 0)
    else $error("flush left words");
  a_full_werr: assert property (reg_wr && reg_addr == 6'h18 && cnt_q == FULL_CNT |=> werr_q)
    else $error("overflow not flagged");
  a_idle_out: assert property (!en[0] |=> pwm_out[0] == ($past(idl[0]) ^ $past(inv[0])))
    else $error("idle level wrong");
  a_stop_idle: assert property (!en[1] |=> st_q[1] == tpm_pkg::TPM_IDLE)
    else $error("disabled channel running");
  a_ser_msb: assert property (en[0] && ser[0] && st_q[0] == tpm_pkg::TPM_RUN && pos_q[0] == 0
    |=> pwm_out[0] == ($past(word_q[0][31]) ^ $past(inv[0])))
    else $error("serial msb wrong");
  a_ms_mark: assert property (en[0] && !ser[0] && ms[0] && st_q[0] == tpm_pkg::TPM_RUN
    && pos_q[0] < word_q[0] |=> pwm_out[0] == !$past(inv[0]))
    else $error("mark level wrong");
  a_period_wrap: assert property (en[0] && st_q[0] == tpm_pkg::TPM_RUN && pos_q[0] + 1 >= rng_q[0]
    && !src[0] |=> pos_q[0] == 0 && word_q[0] == $past(dat_q[0]))
    else $error("period boundary missed");
  a_transfer_request_threshold_gate: assert property (!dma_configuration_q[31] |=> !dma_req && !dma_urgent_request_threshold)
    else $error("dma request while disabled");
  c_serial: cover property (en[0] && ser[0] && st_q[0] == tpm_pkg::TPM_RUN);
  c_full: cover property (cnt_q == FULL_CNT);
  c_gap: cover property (!gap_q[1] ##1 gap_q[1]);
endmodule

// file: hdl/tpm_pkg.sv
// constants and types of the two-channel pulse modulator
package tpm_pkg;
  // ********************
  // register offsets
  // ********************
  localparam logic [5:0] OFS_CTL = 6'h00;
  localparam logic [5:0] OFS_STATUS = 6'h04;
  localparam logic [5:0] OFS_DMA_CONFIGURATION = 6'h08;
  localparam logic [5:0] OFS_PERIOD1 = 6'h10;
  localparam logic [5:0] OFS_VALUE1 = 6'h14;
  localparam logic [5:0] OFS_FIFO = 6'h18;
  localparam logic [5:0] OFS_PERIOD2 = 6'h20;
  localparam logic [5:0] OFS_VALUE2 = 6'h24;
  // ********************
  // control fields, channel 2 at +8
  // ********************
  localparam int B_RUN = 0;
  localparam int B_SER = 1;
  localparam int B_RPT = 2;
  localparam int B_IDLE = 3;
  localparam int B_INV = 4;
  localparam int B_SRC = 5;
  localparam int B_FLUSH = 6;
  localparam int B_MS = 7;
  localparam int CH_STRIDE = 8;
  localparam logic [31:0] CTL_MASK = 32'h0000_bfbf;
  localparam logic [31:0] CTL_RST = 32'h0000_0000;
  // ********************
  // status and dma fields
  // ********************
  localparam int S_FULL = 0;
  localparam int S_EMPTY = 1;
  localparam int S_WERR = 2;
  localparam int S_RERR = 3;
  localparam int S_GAP = 4;
  localparam int S_STATE = 9;
  localparam int D_EN = 31;
  localparam int D_URGENT_REQUEST_THRESHOLD = 8;
  localparam int D_TRANSFER_REQUEST_THRESHOLD = 0;
  localparam logic [31:0] DMA_CONFIGURATION_MASK = 32'h8000_ffff;
  localparam logic [31:0] DMA_CONFIGURATION_RST = 32'h0000_0707;
  localparam logic [31:0] RNG_RST = 32'h0000_0020;
  localparam logic [31:0] DAT_RST = 32'h0000_0000;
  localparam int WORD_BITS = 32;
  localparam int DMA_CHANNEL = 5;
  localparam int CLK_MHZ = 100;
  typedef enum logic [0:0] {TPM_IDLE = 1'b0, TPM_RUN = 1'b1} tpm_state_t;
endpackage

// file: testbench/tpm_pin_sink.sv
// pin-side model counting ones seen on each channel output
`timescale 1ns/1ns
module tpm_pin_sink (
  input wire logic sys_clk,
  input wire logic clr,
  input wire logic [1:0] pins,
  output logic [7:0] ones0,
  output logic [7:0] ones1
);
  // ********************
  // duty counters
  // ********************
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      ones0 <= 8'h00;
      ones1 <= 8'h00;
    end else begin
      ones0 <= ones0 + {7'h00, pins[0]};
      ones1 <= ones1 + {7'h00, pins[1]};
    end
  end
endmodule

// file: testbench/two_channel_pulse_modulator_serialiser_test.sv
// self-checking bench for the two-channel modulator
`timescale 1ns/1ns
module two_channel_pulse_modulator_serialiser_test;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [1:0] pwm_out;
  logic dma_req, dma_urgent_request_threshold;
  logic clr = 1'b1;
  logic [7:0] ones0, ones1;
  int err_total = 0;
  int checked = 0;
  logic [5:0] ra[9] = '{6'h00, 6'h04, 6'h08, 6'h10, 6'h14, 6'h18, 6'h20, 6'h24, 6'h0c};
  logic [31:0] re[9] = '{32'h0, 32'h2, 32'h707, 32'h20, 32'h0, 32'h0, 32'h20, 32'h0, 32'h0};
  tpm_core dut (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pwm_out(pwm_out), .dma_req(dma_req), .dma_urgent_request_threshold(dma_urgent_request_threshold));
  tpm_pin_sink sink (.sys_clk(sys_clk), .clr(clr), .pins(pwm_out), .ones0(ones0),
    .ones1(ones1));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // ********************
  // access and compare tasks
  // ********************
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    #1 cmp($sformatf("reg %h", a), e, reg_rdata);
  endtask
  task automatic chk_bits(input logic [63:0] e0, input logic [63:0] e1, input int n);
    @(posedge sys_clk);
    for (int k = 0; k < n; k++) begin
      @(posedge sys_clk);
      #1 cmp("pin0", {31'h0, e0[n - 1 - k]}, {31'h0, pwm_out[0]});
      cmp("pin1", {31'h0, e1[n - 1 - k]}, {31'h0, pwm_out[1]});
    end
  endtask
  function automatic logic [63:0] gen(input logic [7:0] c, input logic [31:0] d,
      input logic [31:0] r, input int n);
    logic [63:0] x;
    logic [31:0] acc;
    int p;
    logic b;
    x = '0;
    acc = '0;
    for (int k = 0; k < n; k++) begin
      p = k % int'(r);
      acc = acc + d;
      if (c[1]) b = (p < 32) ? d[31 - p] : c[3];
      else if (c[7]) b = (p < int'(d));
      else if (acc >= r) begin
        b = 1'b1;
        acc = acc - r;
      end else b = 1'b0;
      x[n - 1 - k] = b ^ c[4];
    end
    return x;
  endfunction
  task automatic run_cfg(input int ch, input logic [7:0] c, input logic [31:0] r,
      input logic [31:0] d, input int n);
    logic [63:0] e;
    e = gen(c, d, r, n);
    wr(6'h00, 32'h0);
    wr(ch ? 6'h20 : 6'h10, r);
    wr(ch ? 6'h24 : 6'h14, d);
    wr(6'h00, ch ? {16'h0, c, 8'h00} : {24'h0, c});
    if (ch) chk_bits(64'h0, e, n);
    else chk_bits(e, 64'h0, n);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ********************
  // tests
  // ********************
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    clr <= 1'b0;
    for (int i = 0; i < 9; i++) rchk(ra[i], re[i]);
    wr(6'h00, 32'h0000_befe);
    rchk(6'h00, 32'h0000_bebe);
    wr(6'h08, 32'hffff_ffff);
    rchk(6'h08, 32'h8000_ffff);
    wr(6'h00, 32'h0000_0008);
    chk_bits(64'h3, 64'h0, 2);
    run_cfg(0, 8'h03, 4, 32'ha000_0000, 12);
    run_cfg(0, 8'h0b, 36, 32'h8000_0001, 40);
    run_cfg(1, 8'h13, 4, 32'ha000_0000, 8);
    run_cfg(1, 8'h83, 3, 32'h4000_0000, 6);
    run_cfg(0, 8'h81, 8, 3, 16);
    run_cfg(0, 8'h01, 8, 3, 16);
    @(posedge sys_clk) clr <= 1'b1;
    @(posedge sys_clk) clr <= 1'b0;
    repeat (80) @(posedge sys_clk);
    #1 cmp("duty", 32'd30, {24'h0, ones0});
    cmp("duty1", 32'd0, {24'h0, ones1});
    wr(6'h00, 32'h0);
    for (int i = 0; i < 8; i++) wr(6'h18, i);
    rchk(6'h04, 32'h1);
    wr(6'h18, 32'h9);
    rchk(6'h04, 32'h5);
    wr(6'h04, 32'h4);
    rchk(6'h04, 32'h1);
    wr(6'h00, 32'h40);
    rchk(6'h04, 32'h2);
    wr(6'h08, 32'h8000_0307);
    repeat (2) @(posedge sys_clk);
    #1 cmp("urgent_request_threshold", 32'h1, {31'h0, dma_urgent_request_threshold});
    for (int i = 0; i < 3; i++) wr(6'h18, i);
    repeat (2) @(posedge sys_clk);
    #1 cmp("transfer_request_threshold", 32'h1, {31'h0, dma_req});
    cmp("urgent_request_threshold", 32'h0, {31'h0, dma_urgent_request_threshold});
    wr(6'h00, 32'h40);
    wr(6'h10, 32'h4);
    wr(6'h18, 32'ha000_0000);
    wr(6'h00, 32'h23);
    chk_bits(64'ha0, 64'h0, 8);
    rchk(6'h04, 32'h1a);
    wr(6'h00, 32'h0);
    wr(6'h04, 32'h3c);
    wr(6'h18, 32'ha000_0000);
    wr(6'h00, 32'h27);
    chk_bits(64'haaa, 64'h0, 12);
    rchk(6'h04, 32'h202);
    wr(6'h00, 32'h40);
    wr(6'h20, 32'h4);
    wr(6'h18, 32'ha000_0000);
    wr(6'h18, 32'hc000_0000);
    wr(6'h18, 32'h5000_0000);
    wr(6'h18, 32'h3000_0000);
    wr(6'h00, 32'h2323);
    chk_bits(64'h14a, 64'hc3, 9);
    conclude;
  end
  initial begin
    #100000;
    err_total++;
    conclude;
  end
endmodule
